// ### rtl/pmu_map.vh
// Register map, field positions and reset values of the performance event counters
`ifndef PMU_MAP_VH
`define PMU_MAP_VH
// Byte offsets
`define PMU_OFF_CTRL0 8'h00
`define PMU_OFF_CTRL1 8'h04
`define PMU_OFF_CTRLA 8'h08
`define PMU_OFF_STATE 8'h0c
`define PMU_OFF_STATUS 8'h10
`define PMU_OFF_CNT0 8'h20
// CTRL0 fields
`define PMU_C0_FREEZE_ALL 0
`define PMU_C0_FC_USER 1
`define PMU_C0_FC_SUPER 2
`define PMU_C0_FC_WAIT 3
`define PMU_C0_FC_RUN 4
`define PMU_C0_FC_MARK_SET 5
`define PMU_C0_FC_MARK_CLR 6
`define PMU_C0_EXC_EN 7
`define PMU_C0_TRIG_START 8
`define PMU_C0_TRIG_STOP 9
`define PMU_C0_TRIG_LO 10
`define PMU_C0_TRIG_HI 14
`define PMU_C0_MUX_LO 16
`define PMU_C0_MUX_HI 17
`define PMU_C0_CNT_MARKED 18
`define PMU_C0_CNT_UNMARKED 19
// CTRLA fields
`define PMU_CA_THR_LO 0
`define PMU_CA_THR_HI 7
`define PMU_CA_START_LO 8
`define PMU_CA_START_HI 10
`define PMU_CA_STOP_LO 11
`define PMU_CA_STOP_HI 13
`define PMU_CA_SAMPLE_EN 14
// STATE fields
`define PMU_ST_MARK 0
`define PMU_ST_EXT_IRQ 1
`define PMU_ST_SUPER 2
`define PMU_ST_RUN 3
`define PMU_ST_SINGLE_STEP 4
`define PMU_ST_BRANCH_TRACE 5
`define PMU_ST_GRAN 6
// STATUS fields
`define PMU_SS_OVF_LO 0
`define PMU_SS_OVF_HI 7
`define PMU_SS_THR 8
`define PMU_SS_RUNNING 9
// Reset values and sizes
`define PMU_RST_WORD 32'h00000000
`define PMU_LFSR_SEED 16'hace1
`define PMU_GRAN_SHIFT 5
`endif

// ### rtl/pmu_counters.v
// Eight-counter performance event monitor with AXI4-Lite register access
// What this block does
// - Eight independent 32-bit event counters counting concurrently.
// - Counters 0-3 count the event chosen by their CTRL1 select field; 4-7 by a CTRLA nibble, or counter i-4's field if it is zero.
// - Some events count per active cycle, others once per occurrence.
// - Counting filtered by user/supervisor and by marked/unmarked instruction.
// - Counting qualified by privilege and run-versus-wait state via control fields.
// - Indirect events go through shared muxes affecting several counters at once.
// - Some indirect events sum a unit pair's signals into one increment.
// - Counter overflow raises exception request when exception enable bit set.
// - Trigger-start mode: counters frozen until trigger, then count.
// - Trigger-stop mode: counters count until trigger, then freeze.
// - Exception taken only if also enabled by other state bits.
// - Instruction is marked when fetch and dispatch matching both match.
// - One eligible instruction is picked randomly for sampling.
// - Events count marked instructions reaching each pipeline stage.
// - Thread mark bit only gates freezing through the two mark freeze fields.
// - Sampled instruction stage-to-stage cycles over threshold signal an event.
// - Single-step and branch trace modes raise trace exceptions.
// - All control registers and counters clear to zero on reset.
// - Monitor exception is taken only while external interrupt enable is set.
// - Threshold granularity bit selects the thresholder's cycle granularity.
`timescale 1ns/1ps
`include "pmu_map.vh"
module pmu_counters (
   // Clock and reset
   input wire clk,
   input wire arst_n,
   // AXI4-Lite slave
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Core event sources, same clock
   input wire [15:0] direct_cycle_event,
   input wire [15:0] direct_edge_event,
   input wire [7:0] unit_a_event,
   input wire [7:0] unit_b_event,
   input wire fetch_unit_match,
   input wire dispatch_unit_match,
   input wire instr_valid,
   input wire [7:0] stage_pulse,
   input wire instr_complete,
   input wire branch_complete,
   input wire trigger_event_in,
   // Exceptions and sampling
   output reg perf_exc_req,
   output reg trace_exc_req,
   output reg sample_active,
   output reg threshold_event
);
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_WAIT = 3'b010;
   localparam [2:0] ST_MEAS = 3'b100;
   // Register file
   reg [31:0] monitor_control_reg0;
   reg [31:0] monitor_control_reg1;
   reg [31:0] monitor_control_reg_a;
   reg [31:0] state_reg;
   reg [31:0] event_counter [0:7];
   reg [7:0] ovf_flag;
   reg thr_flag;
   reg started;
   reg stopped;
   reg [15:0] lfsr;
   reg [2:0] thr_state;
   reg [31:0] thr_cnt;
   reg [31:0] gran_div;
   reg wr_aw_have;
   reg wr_w_have;
   reg [7:0] wr_addr;
   reg [31:0] wr_data;
   reg [3:0] wr_strb;
   integer i;
   integer j;
   integer k;
   // Decode of control fields
   wire thread_mark_bit = state_reg[`PMU_ST_MARK];
   wire external_irq_enable = state_reg[`PMU_ST_EXT_IRQ];
   wire priv_super = state_reg[`PMU_ST_SUPER];
   wire run_state = state_reg[`PMU_ST_RUN];
   wire threshold_granularity = state_reg[`PMU_ST_GRAN];
   wire freeze_when_mark_set = monitor_control_reg0[`PMU_C0_FC_MARK_SET];
   wire freeze_when_mark_clear = monitor_control_reg0[`PMU_C0_FC_MARK_CLR];
   wire [1:0] mux_sel = monitor_control_reg0[`PMU_C0_MUX_HI:`PMU_C0_MUX_LO];
   wire [4:0] trig_sel = monitor_control_reg0[`PMU_C0_TRIG_HI:`PMU_C0_TRIG_LO];
   // ----------------------------------------------------------------
   // Qualification and marking
   // ----------------------------------------------------------------
   wire marked = instr_valid & fetch_unit_match & dispatch_unit_match;
   wire sampled_pick = marked & (lfsr[3:0] == 4'h0) &
      monitor_control_reg_a[`PMU_CA_SAMPLE_EN] & (thr_state == ST_IDLE);
   wire trig_hit = trig_sel[4] ? trigger_event_in : direct_edge_event[trig_sel[3:0]];
   wire freeze = monitor_control_reg0[`PMU_C0_FREEZE_ALL] |
      (monitor_control_reg0[`PMU_C0_FC_USER] & ~priv_super) |
      (monitor_control_reg0[`PMU_C0_FC_SUPER] & priv_super) |
      (monitor_control_reg0[`PMU_C0_FC_WAIT] & ~run_state) |
      (monitor_control_reg0[`PMU_C0_FC_RUN] & run_state) |
      (freeze_when_mark_set & thread_mark_bit) |
      (freeze_when_mark_clear & ~thread_mark_bit) |
      (monitor_control_reg0[`PMU_C0_TRIG_START] & ~started) |
      (monitor_control_reg0[`PMU_C0_TRIG_STOP] & stopped);
   wire mark_ok = (monitor_control_reg0[`PMU_C0_CNT_MARKED] & marked) |
      (monitor_control_reg0[`PMU_C0_CNT_UNMARKED] & ~marked) |
      ~(monitor_control_reg0[`PMU_C0_CNT_MARKED] |
      monitor_control_reg0[`PMU_C0_CNT_UNMARKED]);
   // ----------------------------------------------------------------
   // Event selection per counter
   // ----------------------------------------------------------------
   // Select codes: 0-15 cycle events, 16-31 edge events, 32-39 muxed unit,
   // 40-47 pair sum, 48-55 marked stage, 56 marked, 57 threshold.
   reg [1:0] incr [0:7];
   reg [5:0] sel;
   reg [2:0] idx;
   always @* begin
      for (i = 0; i < 8; i = i + 1) begin
         sel = (i < 4) ? monitor_control_reg1[i*8 +: 6] : monitor_control_reg_a[(i-4)*4+16 +: 4]
            == 4'h0 ? monitor_control_reg1[(i-4)*8 +: 6] : {2'b00, monitor_control_reg_a[(i-4)*4+16 +: 4]};
         idx = sel[2:0] ^ i[2:0];
         incr[i] = 2'd0;
         case (sel[5:4])
            2'd0: incr[i] = {1'b0, direct_cycle_event[sel[3:0]]};
            2'd1: incr[i] = {1'b0, direct_edge_event[sel[3:0]]};
            2'd2: begin
               if (!sel[3])
                  incr[i] = {1'b0, mux_sel[0] ? unit_b_event[idx] : unit_a_event[idx]};
               else
                  incr[i] = {1'b0, unit_a_event[idx]} + {1'b0, unit_b_event[idx]};
            end
            default: begin
               if (!sel[3])
                  incr[i] = {1'b0, stage_pulse[sel[2:0]] & sample_active};
               else if (sel[2:0] == 3'd0)
                  incr[i] = {1'b0, marked};
               else
                  incr[i] = {1'b0, thr_flag & (sel[2:0] == 3'd1)};
            end
         endcase
         if (freeze || !mark_ok)
            incr[i] = 2'd0;
      end
   end
   // ----------------------------------------------------------------
   // Counters and overflow
   // ----------------------------------------------------------------
   reg [32:0] sum [0:7];
   always @* begin
      for (j = 0; j < 8; j = j + 1)
         sum[j] = {1'b0, event_counter[j]} + {31'd0, incr[j]};
   end
   wire wr_fire = wr_aw_have & wr_w_have & ~s_axi_bvalid;
   wire [31:0] wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (k = 0; k < 8; k = k + 1)
            event_counter[k] <= `PMU_RST_WORD;
         ovf_flag <= 8'h00;
      end else begin
         for (k = 0; k < 8; k = k + 1) begin
            event_counter[k] <= sum[k][31:0];
            if (wr_fire && wr_addr == `PMU_OFF_CNT0 + k[7:0] * 8'h04)
               event_counter[k] <= (event_counter[k] & ~wmask) | (wr_data & wmask);
            if (sum[k][32])
               ovf_flag[k] <= 1'b1;
            else if (wr_fire && wr_addr == `PMU_OFF_STATUS && wr_data[k])
               ovf_flag[k] <= 1'b0;
         end
      end
   end
   // ----------------------------------------------------------------
   // Control registers, triggers, sampling LFSR
   // ----------------------------------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         monitor_control_reg0 <= `PMU_RST_WORD;
         monitor_control_reg1 <= `PMU_RST_WORD;
         monitor_control_reg_a <= `PMU_RST_WORD;
         state_reg <= `PMU_RST_WORD;
         started <= 1'b0;
         stopped <= 1'b0;
         lfsr <= `PMU_LFSR_SEED;
      end else begin
         lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
         if (trig_hit)
            started <= 1'b1;
         if (trig_hit && !freeze)
            stopped <= 1'b1;
         if (wr_fire) begin
            case (wr_addr)
               `PMU_OFF_CTRL0: begin
                  monitor_control_reg0 <= (monitor_control_reg0 & ~wmask) | (wr_data & wmask);
                  // Rearming the trigger modes on any CTRL0 write
                  started <= 1'b0;
                  stopped <= 1'b0;
               end
               `PMU_OFF_CTRL1:
                  monitor_control_reg1 <= (monitor_control_reg1 & ~wmask) | (wr_data & wmask);
               `PMU_OFF_CTRLA:
                  monitor_control_reg_a <= (monitor_control_reg_a & ~wmask) | (wr_data & wmask);
               `PMU_OFF_STATE:
                  state_reg <= (state_reg & ~wmask) | (wr_data & wmask);
               default: ;
            endcase
         end
      end
   end
   // ----------------------------------------------------------------
   // Thresholder on the sampled instruction
   // ----------------------------------------------------------------
   wire [2:0] start_stage = monitor_control_reg_a[`PMU_CA_START_HI:`PMU_CA_START_LO];
   wire [2:0] stop_stage = monitor_control_reg_a[`PMU_CA_STOP_HI:`PMU_CA_STOP_LO];
   wire [31:0] gran_tick_max = threshold_granularity ? ((32'd1 << `PMU_GRAN_SHIFT) - 32'd1)
      : 32'd0;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         thr_state <= ST_IDLE;
         thr_cnt <= 32'd0;
         gran_div <= 32'd0;
         sample_active <= 1'b0;
         thr_flag <= 1'b0;
         threshold_event <= 1'b0;
      end else begin
         threshold_event <= 1'b0;
         if (wr_fire && wr_addr == `PMU_OFF_STATUS && wr_data[`PMU_SS_THR])
            thr_flag <= 1'b0;
         case (thr_state)
            ST_IDLE: begin
               if (sampled_pick) begin
                  thr_state <= ST_WAIT;
                  sample_active <= 1'b1;
               end
            end
            ST_WAIT: begin
               thr_cnt <= 32'd0;
               gran_div <= 32'd0;
               if (stage_pulse[start_stage])
                  thr_state <= ST_MEAS;
            end
            ST_MEAS: begin
               if (gran_div >= gran_tick_max) begin
                  gran_div <= 32'd0;
                  if (thr_cnt != 32'hffffffff)
                     thr_cnt <= thr_cnt + 32'd1;
               end else begin
                  gran_div <= gran_div + 32'd1;
               end
               if (stage_pulse[stop_stage]) begin
                  thr_state <= ST_IDLE;
                  sample_active <= 1'b0;
                  if (thr_cnt > {24'd0, monitor_control_reg_a[`PMU_CA_THR_HI:`PMU_CA_THR_LO]}) begin
                     threshold_event <= 1'b1;
                     thr_flag <= 1'b1;
                  end
               end
            end
            default: thr_state <= ST_IDLE;
         endcase
      end
   end
   // ----------------------------------------------------------------
   // Exceptions
   // ----------------------------------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         perf_exc_req <= 1'b0;
         trace_exc_req <= 1'b0;
      end else begin
         // Level request; drops when software clears the overflow flags
         perf_exc_req <= (|ovf_flag) & monitor_control_reg0[`PMU_C0_EXC_EN]
            & external_irq_enable;
         trace_exc_req <= (state_reg[`PMU_ST_SINGLE_STEP] & instr_complete) |
            (state_reg[`PMU_ST_BRANCH_TRACE] & branch_complete);
      end
   end
   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         wr_aw_have <= 1'b0;
         wr_w_have <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 32'h00000000;
         wr_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            wr_aw_have <= 1'b1;
            wr_addr <= {s_axi_awaddr[7:2], 2'b00};
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wr_w_have <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            wr_aw_have <= 1'b0;
            wr_w_have <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_addr <= `PMU_OFF_STATUS ||
               (wr_addr >= `PMU_OFF_CNT0 && wr_addr < `PMU_OFF_CNT0 + 8'h20)) ? 2'b00 : 2'b10;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'b00;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case ({s_axi_araddr[7:2], 2'b00})
               `PMU_OFF_CTRL0: s_axi_rdata <= monitor_control_reg0;
               `PMU_OFF_CTRL1: s_axi_rdata <= monitor_control_reg1;
               `PMU_OFF_CTRLA: s_axi_rdata <= monitor_control_reg_a;
               `PMU_OFF_STATE: s_axi_rdata <= state_reg;
               `PMU_OFF_STATUS: s_axi_rdata <= {22'd0, ~freeze, thr_flag, ovf_flag};
               default: begin
                  if (s_axi_araddr >= `PMU_OFF_CNT0 && s_axi_araddr < `PMU_OFF_CNT0 + 8'h20)
                     s_axi_rdata <= event_counter[s_axi_araddr[4:2]];
                  else begin
                     s_axi_rdata <= 32'h00000000;
                     s_axi_rresp <= 2'b10;
                  end
               end
            endcase
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule // pmu_counters

// ### testbench/pec_counters_asserts.sv
// Concurrent checks on the performance event counter ports
`timescale 1ns/1ps
module pec_counters_asserts (
   // Clock and reset
   input wire clk,
   input wire arst_n,
   // Register bus
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   // Core side
   input wire instr_complete,
   input wire branch_complete,
   input wire perf_exc_req,
   input wire trace_exc_req
);
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking pec_cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   aw_lock_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("write address ready stayed high after a take");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped or changed before acceptance");
   b_order_a: assert property ($rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready))
      else $error("write response without both channels taken");
   b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write channels open while a response is pending");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read response dropped or changed before acceptance");
   r_time_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late after address take");
   r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response repeated after acceptance");
   r_err_a: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h00000000)
      else $error("refused read returned nonzero data");
   trace_src_a: assert property ($rose(trace_exc_req) |-> $past(instr_complete || branch_complete))
      else $error("trace request without a completion");

   wr_err_c: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'b10);
   rd_wait_c: cover property (s_axi_rvalid && !s_axi_rready);
   exc_c: cover property ($rose(perf_exc_req));
   trace_c: cover property ($rose(trace_exc_req));
endmodule // pec_counters_asserts

bind pmu_counters pec_counters_asserts i_pec_counters_asserts (
   .clk(clk), .arst_n(arst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .instr_complete(instr_complete),
   .branch_complete(branch_complete), .perf_exc_req(perf_exc_req),
   .trace_exc_req(trace_exc_req));

// ### testbench/test_pmu_counters.sv
// Self-checking testbench for the performance event counters
`timescale 1ns/1ps
`include "pmu_map.vh"
module test_pmu_counters;
   typedef struct packed {
      logic [7:0] sel, ua, ub, st;
      logic [15:0] cyc, edg;
      logic mark;
      logic [31:0] ctrl0, exp;
      logic [3:0] n;
   } pec_row_t;
   logic clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr, unit_a_event, unit_b_event;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [15:0] direct_cycle_event, direct_edge_event;
   logic mark_in, instr_complete, branch_complete, trigger_event_in, seen;
   logic perf_exc_req, trace_exc_req, sample_active, threshold_event;
   int bad_count, samples_checked;
   pec_row_t rows[17] = '{
      '{3, 0, 0, 0, 16'h8, 0, 0, 0, 5, 5},
      '{3, 0, 0, 0, 16'h4, 0, 0, 0, 0, 5},
      '{20, 0, 0, 0, 0, 16'h10, 0, 0, 3, 6},
      '{33, 2, 0, 0, 0, 0, 0, 0, 4, 4},
      '{33, 2, 0, 0, 0, 0, 0, 32'h10000, 0, 4},
      '{33, 0, 2, 0, 0, 0, 0, 32'h10000, 4, 4},
      '{41, 2, 2, 0, 0, 0, 0, 0, 8, 4},
      '{3, 0, 0, 4, 16'h8, 0, 0, 32'h4, 0, 4},
      '{3, 0, 0, 4, 16'h8, 0, 0, 32'h2, 4, 4},
      '{3, 0, 0, 8, 16'h8, 0, 0, 32'h10, 0, 4},
      '{3, 0, 0, 8, 16'h8, 0, 0, 32'h8, 4, 4},
      '{3, 0, 0, 1, 16'h8, 0, 0, 32'h20, 0, 4},
      '{3, 0, 0, 1, 16'h8, 0, 0, 32'h40, 4, 4},
      '{3, 0, 0, 0, 16'h8, 0, 0, 32'h1, 0, 4},
      '{3, 0, 0, 0, 16'h8, 0, 0, 32'h40000, 0, 4},
      '{3, 0, 0, 0, 16'h8, 0, 1, 32'h40000, 4, 4},
      '{56, 0, 0, 0, 0, 0, 1, 0, 4, 4}};

   pmu_counters i_pmu_counters (
      .clk(clk), .arst_n(arst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .direct_cycle_event(direct_cycle_event), .direct_edge_event(direct_edge_event),
      .unit_a_event(unit_a_event), .unit_b_event(unit_b_event), .fetch_unit_match(mark_in),
      .dispatch_unit_match(mark_in), .instr_valid(mark_in), .stage_pulse(8'h00),
      .instr_complete(instr_complete), .branch_complete(branch_complete),
      .trigger_event_in(trigger_event_in), .perf_exc_req(perf_exc_req),
      .trace_exc_req(trace_exc_req), .sample_active(sample_active),
      .threshold_event(threshold_event));

   // ---------------------------------------------------------------
   // Bus and compare tasks
   // ---------------------------------------------------------------
   task chk32(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task chk1(input logic got, input logic exp);
      chk32({31'h0, got}, {31'h0, exp});
   endtask
   // Each task starts on a fresh edge so no signal is driven twice in one step
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 0;
      w_ok = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (!aw_ok && s_axi_awready) begin
            aw_ok = 1;
            s_axi_awvalid <= 0;
         end
         if (!w_ok && s_axi_wready) begin
            w_ok = 1;
            s_axi_wvalid <= 0;
         end
      end
      while (!s_axi_bvalid) @(posedge clk);
      resp = s_axi_bresp;
      s_axi_bready <= 0;
   endtask
   // Ready is raised a cycle late on purpose to exercise response holding
   task rd(input logic [7:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      while (!s_axi_rvalid) @(posedge clk);
      s_axi_rready <= 1;
      @(posedge clk);
      rd_data = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 0;
   endtask
   task trace_try(input logic [7:0] st, input logic br, input logic exp);
      wr(`PMU_OFF_STATE, {24'h0, st});
      @(posedge clk);
      if (br) branch_complete <= 1;
      else instr_complete <= 1;
      seen = 0;
      @(posedge clk);
      {instr_complete, branch_complete} <= 2'b00;
      repeat (2) begin
         #1 seen = seen | trace_exc_req;
         @(posedge clk);
      end
      chk1(seen, exp);
   endtask
   task summarize;
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Stimulus
   // ---------------------------------------------------------------
   initial begin
      clk = 0;
      forever #10 clk = ~clk;
   end
   initial begin
      repeat (30000) @(posedge clk);
      bad_count++;
      $display("ERROR %0t: watchdog expired", $time);
      summarize;
   end
   initial begin
      {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, unit_a_event, unit_b_event} = '0;
      {direct_cycle_event, direct_edge_event, mark_in} = '0;
      {instr_complete, branch_complete, trigger_event_in} = '0;
      bad_count = 0;
      samples_checked = 0;
      repeat (20) @(posedge clk);
      arst_n <= 1;
      for (int k = 0; k < 12; k++) begin
         rd(k < 4 ? 8'(k * 4) : 8'(8'h20 + (k - 4) * 4));
         chk32(rd_data, `PMU_RST_WORD);
      end
      foreach (rows[i]) begin
         wr(`PMU_OFF_CTRL0, rows[i].ctrl0);
         wr(`PMU_OFF_STATE, {24'h0, rows[i].st});
         wr(`PMU_OFF_CTRL1, {24'h0, rows[i].sel});
         wr(`PMU_OFF_CNT0, 32'h0);
         for (int k = 0; k < rows[i].n; k++) begin
            @(posedge clk);
            direct_cycle_event <= rows[i].cyc;
            direct_edge_event <= k[0] ? 16'h0 : rows[i].edg;
            unit_a_event <= rows[i].ua;
            unit_b_event <= rows[i].ub;
            mark_in <= rows[i].mark;
         end
         @(posedge clk);
         {direct_cycle_event, direct_edge_event, unit_a_event, unit_b_event, mark_in} <= '0;
         rd(`PMU_OFF_CNT0);
         chk32(rd_data, rows[i].exp);
      end
      wr(`PMU_OFF_CTRL1, 32'h00000003);
      wr(`PMU_OFF_CTRL0, 32'h00000900);
      wr(`PMU_OFF_CNT0, 32'h0);
      @(posedge clk);
      direct_cycle_event <= 16'h8;
      repeat (4) @(posedge clk);
      rd(`PMU_OFF_CNT0);
      chk32(rd_data, 32'h0);
      @(posedge clk);
      direct_edge_event <= 16'h4;
      @(posedge clk);
      direct_edge_event <= 16'h0;
      repeat (4) @(posedge clk);
      direct_cycle_event <= 16'h0;
      rd(`PMU_OFF_CNT0);
      chk1(rd_data >= 3 && rd_data <= 5, 1);
      wr(`PMU_OFF_CTRL0, 32'h00004200);
      wr(`PMU_OFF_CNT0, 32'h0);
      @(posedge clk);
      direct_cycle_event <= 16'h8;
      repeat (4) @(posedge clk);
      trigger_event_in <= 1;
      @(posedge clk);
      trigger_event_in <= 0;
      repeat (4) @(posedge clk);
      direct_cycle_event <= 16'h0;
      rd(`PMU_OFF_CNT0);
      chk1(rd_data >= 4 && rd_data <= 6, 1);
      wr(`PMU_OFF_CTRL0, 32'h00000080);
      wr(`PMU_OFF_STATE, 32'h0);
      wr(`PMU_OFF_CNT0, 32'hfffffffe);
      @(posedge clk);
      direct_cycle_event <= 16'h8;
      repeat (2) @(posedge clk);
      direct_cycle_event <= 16'h0;
      rd(`PMU_OFF_CNT0);
      chk32(rd_data, 32'h0);
      rd(`PMU_OFF_STATUS);
      chk32(rd_data & 32'hff, 32'h1);
      chk1(perf_exc_req, 0);
      wr(`PMU_OFF_STATE, 32'h2);
      repeat (2) @(posedge clk);
      #1 chk1(perf_exc_req, 1);
      wr(`PMU_OFF_STATUS, 32'h1);
      repeat (2) @(posedge clk);
      #1 chk1(perf_exc_req, 0);
      trace_try(8'h10, 0, 1);
      trace_try(8'h20, 1, 1);
      trace_try(8'h00, 0, 0);
      trace_try(8'h20, 0, 0);
      rd(8'h80);
      chk32(rd_data, 32'h0);
      chk32({30'h0, resp}, 32'h2);
      wr(8'h14, 32'h1);
      chk32({30'h0, resp}, 32'h2);
      wr(`PMU_OFF_CTRL0, 32'h00000080);
      @(posedge clk);
      arst_n <= 0;
      repeat (2) @(posedge clk);
      arst_n <= 1;
      rd(`PMU_OFF_CTRL0);
      chk32(rd_data, `PMU_RST_WORD);
      summarize;
   end
endmodule // test_pmu_counters
